// file: pkg/dcsw_pkg.sv
// Purpose: Shared constants and carriers for the drive command/condition word logic.
// Assumes: 16-bit words, one clock domain, synchronous active-low reset.
// Notes:   Register map of the plain software port lives here.
package dcsw_pkg;

  // Command word bit positions
  localparam int CW_OFF1    = 0;
  localparam int CW_OFF2    = 1;
  localparam int CW_OFF3    = 2;
  localparam int CW_COAST   = 3;
  localparam int CW_QSTOP   = 4;
  localparam int CW_HOLD    = 5;
  localparam int CW_START   = 6;
  localparam int CW_RESET   = 7;
  localparam int CW_JOG1    = 8;
  localparam int CW_JOG2    = 9;
  localparam int CW_VALID   = 10;
  localparam int CW_SLOW    = 11;
  localparam int CW_CATCH   = 12;
  localparam int CW_SET_LSB = 13;
  localparam int CW_SET_MSB = 14;
  localparam int CW_REV     = 15;

  // Register offsets of the software port (word index)
  localparam logic [3:0] REG_CMD_ACTIVE = 4'h0;
  localparam logic [3:0] REG_CONDITION  = 4'h1;
  localparam logic [3:0] REG_SOURCE_SEL = 4'h2;
  localparam logic [3:0] REG_CONFIG     = 4'h3;
  localparam logic [3:0] REG_DRIVE_STAT = 4'h4;
  localparam logic [3:0] REG_ACTIONS    = 4'h5;

  // Config register fields
  localparam int CFG_MULTI_SETUP = 0;
  localparam int CFG_RELAY_EN    = 1;

  // Source-select field positions, two bits per function
  localparam int SRC_COAST_LSB = 0;
  localparam int SRC_QSTOP_LSB = 2;
  localparam int SRC_START_LSB = 4;
  localparam int SRC_SETUP_LSB = 6;
  localparam int SRC_REV_LSB   = 8;

  // Condition word bit positions
  localparam int ST_CTRL_READY = 0;
  localparam int ST_DRV_READY  = 1;
  localparam int ST_ENABLE     = 2;
  localparam int ST_TRIP       = 3;
  localparam int ST_OFF2_ECHO  = 4;
  localparam int ST_OFF3_ECHO  = 5;
  localparam int ST_NO_START   = 6;
  localparam int ST_WARNING    = 7;
  localparam int ST_AT_REF     = 8;
  localparam int ST_BUS_CTRL   = 9;
  localparam int ST_IN_LIMITS  = 10;
  localparam int ST_RUNNING    = 11;
  localparam int ST_OVERLOAD   = 12;
  localparam int ST_VOLTAGE    = 13;
  localparam int ST_TORQUE     = 14;
  localparam int ST_TIMER      = 15;

  // Reset values
  localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;
  localparam logic [15:0] SRC_RESET_VALUE = 16'h0000;
  localparam logic [15:0] CFG_RESET_VALUE = 16'h0000;
  localparam logic [15:0] ZERO16          = 16'h0000;

  // Source selection, two bits per function
  typedef enum logic [1:0] {
    DCSW_SRC_DIGITAL = 2'b00,
    DCSW_SRC_BUS     = 2'b01,
    DCSW_SRC_OR      = 2'b10,
    DCSW_SRC_AND     = 2'b11
  } dcsw_src_t;

  // Drive status inputs from motor control
  typedef struct packed {
    logic trip;
    logic power_ok;
    logic warning;
    logic at_reference;
    logic bus_allowed;
    logic in_limits;
    logic freq_nonzero;
    logic overload_auto;
    logic dc_out_of_range;
    logic torque_exceeded;
    logic thermal_over;
    logic running;
    logic switch_off_ack;
  } dcsw_drive_stat_t;

  // Commands decoded to motor control
  typedef struct packed {
    logic       ramp_stop;
    logic       coast_stop;
    logic       quick_stop;
    logic       hold_freq;
    logic       start_ok;
    logic       reset_pulse;
    logic       jog1;
    logic       jog2;
    logic       slow_down;
    logic       catch_up;
    logic [1:0] setup_sel;
    logic       reverse;
    logic       relay;
  } dcsw_cmd_t;

  // Digital-input counterparts
  typedef struct packed {
    logic       coast_n;
    logic       qstop_n;
    logic       start;
    logic [1:0] setup;
    logic       reverse;
  } dcsw_din_t;

endpackage : dcsw_pkg

// file: logic/dcsw_core.sv
// Purpose: Decodes the fieldbus command word and builds the condition word.
// Assumes: Command word arrives with a one-cycle strobe from same-clock logic;
//          digital inputs come from pins and are synchronised here.
// Notes:   All outputs are registered.
// What this block does
// - Bit 04 low forces quick stop
// - Bit 05 low holds output frequency
// - Bit 06 low ramp stop; relay at 0 Hz
// - Reset only on rising bit 07
// - Jogs need bit04 low, bits00-03 high
// - Bit 10 low ignores whole word
// - Bit 11 slows reference down
// - Bit 12 catches up; slow wins
// - Bits 13/14 pick set-up, gated
// - Bit 15 reverses under serial-type source
// - Bus bits combine with digital inputs
// - Ready bits from off bits, trip, power
// - Enable bit needs off bits, no trip
// - Trip bit holds until reset
// - Status 04/05 mirror command 01/02
// - Start-not-possible set and clear
// - Warning bit follows any warning
// - Speed-match bit
// - Bus control bit
// - Frequency-limit bit
// - In-operation bit
// - Overload, voltage, torque, timer bits
// - Bit 00 low ramp stop
// - Bit 01 low coasting stop; relay at 0 Hz
// - Bit 02 low quick stop
// - Bit 03 low coasting stop
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module dcsw_core
  import dcsw_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fieldbus command word
  input  wire logic [15:0]      command_word,
  input  wire logic             command_strobe,
  // Drive status from motor control (same clock)
  input  wire dcsw_drive_stat_t drive_stat,
  // Digital inputs (pins)
  input  wire dcsw_din_t        din_pins,
  // Software register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  // Decoded commands and condition word
  output dcsw_cmd_t             cmd_out,
  output logic      [15:0]      condition_word
);

  logic [15:0]      cmd_active;
  logic [15:0]      src_sel;
  logic [15:0]      cfg;
  logic             reset_seen;
  logic             trip_latched;
  logic             start_blocked;
  dcsw_din_t        din_meta;
  dcsw_din_t        din_sync;
  dcsw_cmd_t        next_cmd;
  logic [15:0]      next_cond;
  logic             bus_reset_rise;
  logic             coast_bus_n;
  logic             qstop_bus_n;
  logic             start_bus;

  // Two-flop synchroniser on digital inputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      din_meta <= '0;
      din_sync <= '0;
    end else begin
      din_meta <= din_pins;
      din_sync <= din_meta;
    end
  end

  // Latch the word only when marked valid
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_active <= CMD_RESET_VALUE;
    end else if (command_strobe && command_word[CW_VALID]) begin
      cmd_active <= command_word;
    end
  end

  // Rising-edge detector of the reset bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reset_seen <= 1'b0;
    end else begin
      reset_seen <= cmd_active[CW_RESET];
    end
  end
  assign bus_reset_rise = cmd_active[CW_RESET] && !reset_seen;

  // Source combining per function
  function automatic logic combine(input logic [1:0] sel, input logic bus_b, input logic din_b);
    unique case (dcsw_src_t'(sel))
      DCSW_SRC_DIGITAL: combine = din_b;
      DCSW_SRC_BUS:     combine = bus_b;
      DCSW_SRC_OR:      combine = bus_b | din_b;
      DCSW_SRC_AND:     combine = bus_b & din_b;
    endcase
  endfunction : combine

  // Software configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      src_sel <= SRC_RESET_VALUE;
      cfg     <= CFG_RESET_VALUE;
    end else if (reg_wr) begin
      if (reg_addr == REG_SOURCE_SEL) src_sel <= reg_wdata;
      if (reg_addr == REG_CONFIG)     cfg     <= reg_wdata;
    end
  end

  // Command decode
  always_comb begin
    logic [1:0] bus_set;
    logic [1:0] din_set;
    logic       jog_ok;
    logic       rev_bus_ok;
    bus_set = {cmd_active[CW_SET_MSB], cmd_active[CW_SET_LSB]};
    din_set = din_sync.setup;
    jog_ok = !cmd_active[CW_QSTOP] && (&cmd_active[CW_COAST:CW_OFF1]);
    rev_bus_ok = (dcsw_src_t'(src_sel[SRC_REV_LSB +: 2]) != DCSW_SRC_DIGITAL);
    coast_bus_n = combine(src_sel[SRC_COAST_LSB +: 2], cmd_active[CW_COAST],
                          din_sync.coast_n);
    qstop_bus_n = combine(src_sel[SRC_QSTOP_LSB +: 2], cmd_active[CW_QSTOP],
                          din_sync.qstop_n);
    start_bus   = combine(src_sel[SRC_START_LSB +: 2], cmd_active[CW_START],
                          din_sync.start);
    next_cmd = '0;
    next_cmd.ramp_stop   = !cmd_active[CW_OFF1] || !start_bus;
    next_cmd.coast_stop  = !cmd_active[CW_OFF2] || !coast_bus_n;
    next_cmd.quick_stop  = !cmd_active[CW_OFF3] || !qstop_bus_n;
    next_cmd.hold_freq   = !cmd_active[CW_HOLD];
    next_cmd.start_ok    = start_bus && qstop_bus_n && coast_bus_n
                           && (&cmd_active[CW_OFF3:CW_OFF1]);
    next_cmd.reset_pulse = bus_reset_rise;
    next_cmd.jog1        = cmd_active[CW_JOG1] && jog_ok;
    next_cmd.jog2        = cmd_active[CW_JOG2] && jog_ok;
    next_cmd.slow_down   = cmd_active[CW_SLOW];
    next_cmd.catch_up    = cmd_active[CW_CATCH] && !cmd_active[CW_SLOW];
    // Set-up changes only in multi-set-up mode; stays put otherwise
    if (cfg[CFG_MULTI_SETUP]) begin
      next_cmd.setup_sel = {combine(src_sel[SRC_SETUP_LSB +: 2], bus_set[1], din_set[1]),
                            combine(src_sel[SRC_SETUP_LSB +: 2], bus_set[0], din_set[0])};
    end else begin
      next_cmd.setup_sel = cmd_out.setup_sel;
    end
    next_cmd.reverse = rev_bus_ok ?
                       combine(src_sel[SRC_REV_LSB +: 2], cmd_active[CW_REV], din_sync.reverse) :
                       din_sync.reverse;
    // Relay closes at standstill after any stop request
    next_cmd.relay = cfg[CFG_RELAY_EN] && !drive_stat.freq_nonzero &&
                     (next_cmd.ramp_stop || next_cmd.coast_stop || next_cmd.quick_stop);
  end

  // Command outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_out <= '0;
    end else begin
      cmd_out <= next_cmd;
    end
  end

  // Trip is held until a reset arrives; a new trip wins over reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trip_latched <= 1'b0;
    end else if (drive_stat.trip) begin
      trip_latched <= 1'b1;
    end else if (bus_reset_rise) begin
      trip_latched <= 1'b0;
    end
  end

  // Start-not-possible flag, set at power-up
  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_blocked <= 1'b1;
    end else if (drive_stat.switch_off_ack || !cmd_active[CW_OFF2] || !cmd_active[CW_OFF3]) begin
      start_blocked <= 1'b1;
    end else if (!cmd_active[CW_OFF1] && cmd_active[CW_OFF2] && cmd_active[CW_OFF3]
                 && cmd_active[CW_VALID]) begin
      start_blocked <= 1'b0;
    end
  end

  // Condition word assembly
  always_comb begin
    logic offs_on;
    offs_on = &cmd_active[CW_OFF3:CW_OFF1];
    next_cond = ZERO16;
    next_cond[ST_CTRL_READY] = offs_on && !trip_latched;
    next_cond[ST_DRV_READY]  = offs_on && !trip_latched && drive_stat.power_ok;
    next_cond[ST_ENABLE]     = offs_on && !trip_latched;
    next_cond[ST_TRIP]       = trip_latched;
    next_cond[ST_OFF2_ECHO]  = cmd_active[CW_OFF2];
    next_cond[ST_OFF3_ECHO]  = cmd_active[CW_OFF3];
    next_cond[ST_NO_START]   = start_blocked;
    next_cond[ST_WARNING]    = drive_stat.warning;
    next_cond[ST_AT_REF]     = drive_stat.at_reference;
    next_cond[ST_BUS_CTRL]   = drive_stat.bus_allowed;
    next_cond[ST_IN_LIMITS]  = drive_stat.in_limits;
    next_cond[ST_RUNNING]    = start_bus || drive_stat.freq_nonzero;
    next_cond[ST_OVERLOAD]   = drive_stat.overload_auto;
    next_cond[ST_VOLTAGE]    = drive_stat.dc_out_of_range;
    next_cond[ST_TORQUE]     = drive_stat.torque_exceeded;
    next_cond[ST_TIMER]      = drive_stat.thermal_over;
  end

  // Condition word register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      condition_word <= ZERO16;
    end else begin
      condition_word <= next_cond;
    end
  end

  // Register read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= ZERO16;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_CMD_ACTIVE: reg_rdata <= cmd_active;
        REG_CONDITION:  reg_rdata <= condition_word;
        REG_SOURCE_SEL: reg_rdata <= src_sel;
        REG_CONFIG:     reg_rdata <= cfg;
        REG_DRIVE_STAT: reg_rdata <= 16'(drive_stat);
        REG_ACTIONS:    reg_rdata <= 16'(cmd_out[13:1]);
        default:        reg_rdata <= ZERO16;
      endcase
    end else begin
      reg_rdata <= ZERO16;
    end
  end

endmodule : dcsw_core

// file: testbench/dcsw_master.sv
// Purpose: Fieldbus master model that sends command telegrams.
// Assumes: A telegram is one strobe cycle that carries a whole word.
// Notes:   Between telegrams the word lines show the inverse of the last word.
`timescale 1ns/1ps
module dcsw_master (
  // Clock
  input  wire logic        clk,
  // Telegram lines
  output logic      [15:0] command_word,
  output logic             command_strobe
);
  // Lines idle low until the first telegram
  initial begin
    command_word   = 16'h0000;
    command_strobe = 1'b0;
  end
  // Whole word per telegram; stale data is inverted afterwards
  task automatic send(input logic [15:0] word);
    @(posedge clk);
    command_word   <= word;
    command_strobe <= 1'b1;
    @(posedge clk);
    command_word   <= ~word;
    command_strobe <= 1'b0;
  endtask : send
endmodule : dcsw_master

// file: testbench/dcsw_core_asserts.sv
// Purpose: Port checks of the command and condition word logic.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Word answer lands two edges after it is taken.
`timescale 1ns/1ps
module dcsw_core_asserts
  import dcsw_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             nrst,
  // Watched ports
  input wire logic [15:0]      command_word,
  input wire logic             command_strobe,
  input wire dcsw_drive_stat_t drive_stat,
  input wire dcsw_cmd_t        cmd_out,
  input wire logic [15:0]      condition_word
);
  logic        acc;
  logic [1:0]  ac;
  logic [15:0] w1;
  logic [15:0] w2;
  logic [3:0]  rq;
  assign acc = nrst && command_strobe && command_word[CW_VALID];
  // Delay line of accepted words and reset requests
  always_ff @(posedge clk) begin
    ac <= {ac[0], acc};
    w1 <= command_word;
    w2 <= w1;
    rq <= {rq[2:0], acc && command_word[CW_RESET]};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ign_word_a: assert property (
    !ac[1] |-> $stable({cmd_out.jog1, cmd_out.jog2, cmd_out.slow_down, cmd_out.catch_up}))
    else $error("commands moved without a valid word");
  hold_freq_a: assert property (ac[1] |-> cmd_out.hold_freq == !w2[CW_HOLD])
    else $error("hold output wrong");
  catch_prio_a: assert property (
    ac[1] |-> cmd_out.catch_up == (w2[CW_CATCH] && !w2[CW_SLOW]))
    else $error("catch-up wrong");
  jog_gate_a: assert property (
    ac[1] |-> cmd_out.jog2 == (w2[CW_JOG2] && w2[4:0] == 5'h0f))
    else $error("jog gating wrong");
  reset_pulse_a: assert property (
    cmd_out.reset_pulse |-> rq[1] ##1 !cmd_out.reset_pulse)
    else $error("reset pulse wrong");
  mirror_bits_a: assert property (
    ac[1] |-> condition_word[5:4] == w2[2:1])
    else $error("mirror bits wrong");
  trip_hold_a: assert property (
    condition_word[3] && rq == 4'h0 && !(acc && command_word[CW_RESET]) |=> condition_word[3])
    else $error("trip bit dropped without reset");
  enable_needs_a: assert property (
    condition_word[2] |-> condition_word[5:4] == 2'b11)
    else $error("enable without off bits high");
  warn_bit_a: assert property (
    $past(nrst) |-> condition_word[7] == $past(drive_stat.warning))
    else $error("warning bit wrong");
  fault_bits_a: assert property ($past(nrst) |-> condition_word[15:12] ==
    $past({drive_stat.thermal_over, drive_stat.torque_exceeded,
           drive_stat.dc_out_of_range, drive_stat.overload_auto}))
    else $error("fault bits wrong");
endmodule : dcsw_core_asserts

bind dcsw_core dcsw_core_asserts chk_u (
  .clk(clk), .nrst(nrst), .command_word(command_word), .command_strobe(command_strobe),
  .drive_stat(drive_stat), .cmd_out(cmd_out), .condition_word(condition_word)
);

// file: testbench/dcsw_core_bench.sv
// Purpose: Self-checking bench for the command and condition word logic.
// Assumes: Answers stand two edges after the word is taken.
// Notes:   Random words from a fixed LFSR, corners first.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module dcsw_core_bench
  import dcsw_pkg::*;
;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  wire logic [15:0] command_word;
  wire logic        command_strobe;
  dcsw_drive_stat_t drive_stat = '0;
  dcsw_drive_stat_t ds;
  dcsw_din_t        din_pins = '0;
  dcsw_din_t        pn;
  logic             m = 1'b0;
  logic             sb = 1'b1;
  logic [15:0]      wp = 16'h0000;
  logic [3:0]       reg_addr = 4'h0;
  logic [15:0]      reg_wdata = 16'h0000;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [15:0]      reg_rdata;
  dcsw_cmd_t        cmd_out;
  logic [15:0]      condition_word;
  logic [31:0]      lf = 32'h0000_cb3e;
  logic [15:0]      w;
  logic [15:0]      r;
  logic [3:0]       n;
  logic [15:0]      corner [4] = '{16'h1f0f, 16'hffff, 16'h0400, 16'h670f};
  int               error_cnt = 0;
  int               n_compared = 0;
  wire logic [9:0]  got_cmd = {cmd_out.jog1, cmd_out.jog2, cmd_out.slow_down,
    cmd_out.catch_up, cmd_out.setup_sel, cmd_out.reverse, cmd_out.hold_freq,
    cmd_out.coast_stop, cmd_out.quick_stop};
  wire logic [2:0]  got_run = {cmd_out.ramp_stop, cmd_out.start_ok, cmd_out.relay};

  // 125 MHz clock
  always #4 clk = ~clk;

  dcsw_master master_u (.clk(clk), .command_word(command_word),
                        .command_strobe(command_strobe));
  dcsw_core dut_u (.clk(clk), .nrst(nrst), .command_word(command_word),
    .command_strobe(command_strobe), .drive_stat(drive_stat), .din_pins(din_pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_out(cmd_out), .condition_word(condition_word));

  // Next LFSR state
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // Expected commands; m picks the mixed source map, else all bus
  function automatic logic [9:0] exp_cmd(input logic [15:0] x, input dcsw_din_t p,
                                         input logic m);
    logic jg;
    logic cn;
    jg = x[4:0] == 5'h0f;
    cn = m ? p.coast_n : x[3];
    return {x[8] && jg, x[9] && jg, x[11], x[12] && !x[11],
            m ? (x[14:13] & p.setup) : x[14:13], m ? p.reverse : x[15], !x[5],
            !x[1] || !cn, !x[2] || !x[4]};
  endfunction : exp_cmd
  // Expected ramp stop, start permission and relay with relay enabled
  function automatic logic [2:0] exp_run(input logic [15:0] x, input dcsw_drive_stat_t d,
                                         input dcsw_din_t p, input logic m);
    logic st;
    logic cn;
    logic rs;
    st = m ? (x[6] || p.start) : x[6];
    cn = m ? p.coast_n : x[3];
    rs = !x[0] || !st;
    return {rs, st && x[4] && cn && (&x[2:0]),
            !d.freq_nonzero && (rs || !x[1] || !cn || !x[2] || !x[4])};
  endfunction : exp_run
  // Expected condition word; s is the start-not-possible flag
  function automatic logic [15:0] exp_cond(input logic [15:0] x, input dcsw_drive_stat_t d,
                                           input dcsw_din_t p, input logic m, input logic s);
    logic rdy;
    logic st;
    rdy = &x[2:0] && !d.trip;
    st = m ? (x[6] || p.start) : x[6];
    return {d.thermal_over, d.torque_exceeded, d.dc_out_of_range, d.overload_auto,
            st || d.freq_nonzero, d.in_limits, d.bus_allowed, d.at_reference, d.warning,
            s, x[2:1], 1'b0, rdy, rdy && d.power_ok, rdy};
  endfunction : exp_cond
  // Start-not-possible flag after one edge with word x and status d
  function automatic logic upd_sb(input logic s, input logic [15:0] x,
                                  input dcsw_drive_stat_t d);
    if (d.switch_off_ack || !x[1] || !x[2]) return 1'b1;
    if (!x[0] && x[10]) return 1'b0;
    return s;
  endfunction : upd_sb
  // Register write, one strobe cycle, then one idle edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask : wr
  // Register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd
  // Counts, verdict and end of run
  task automatic stop_test;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(REG_SOURCE_SEL, r); `CHK(r, SRC_RESET_VALUE)
    rd(4'hf, r); `CHK(r, ZERO16)
    wr(REG_SOURCE_SEL, 16'h0155);
    wr(REG_CONFIG, 16'h0003);
    rd(REG_SOURCE_SEL, r); `CHK(r, 16'h0155)
    for (int i = 0; i < 40; i++) begin
      lf = nxt(lf);
      w = (i < 4) ? corner[i] : lf[15:0];
      w[CW_VALID] = 1'b1;
      ds = dcsw_drive_stat_t'(lf[28:16]);
      ds.trip = 1'b0;
      ds.running = 1'b0;
      pn = dcsw_din_t'(lf[31:26]);
      // Second half runs a mixed source map
      if (i == 20) begin
        wr(REG_SOURCE_SEL, 16'h00e4);
        m = 1'b1;
      end
      drive_stat <= ds;
      din_pins <= pn;
      sb = upd_sb(sb, wp, ds);
      master_u.send(w);
      repeat (2) @(posedge clk);
      `CHK(got_cmd, exp_cmd(w, pn, m))
      `CHK(got_run, exp_run(w, ds, pn, m))
      `CHK(condition_word, exp_cond(w, ds, pn, m, sb))
      sb = upd_sb(sb, w, ds);
      wp = w;
      master_u.send({w[15:11], 1'b0, ~w[9:0]});
      repeat (2) @(posedge clk);
      `CHK(got_cmd, exp_cmd(w, pn, m))
    end
    drive_stat.trip <= 1'b1;
    repeat (3) @(posedge clk);
    drive_stat.trip <= 1'b0;
    master_u.send(16'h047f);
    repeat (3) @(posedge clk);
    `CHK(condition_word[3], 1'b1)
    // A rising bit 07 resets once; a repeated 1 does not
    for (int k = 0; k < 2; k++) begin
      n = 4'h0;
      master_u.send(16'h04ff);
      repeat (5) begin
        @(posedge clk);
        if (cmd_out.reset_pulse === 1'b1) n++;
      end
      `CHK(n, (k == 0) ? 4'h1 : 4'h0)
      `CHK(condition_word[3], 1'b0)
    end
    // Set-up bits are held once multi-set-up mode is off
    wr(REG_CONFIG, 16'h0002);
    master_u.send(16'h6400);
    repeat (2) @(posedge clk);
    `CHK(cmd_out.setup_sel, 2'b00)
    master_u.send(16'h0000);
    rd(REG_CMD_ACTIVE, r); `CHK(r, 16'h6400)
    stop_test();
  end
endmodule : dcsw_core_bench
